// [bench/acc_stack_monitor.sv]
/* port checker for the accumulator stack arithmetic unit.
   assumes it is bound to accumulator_stack_arith and shares its single clock. */
`timescale 1ns/10ps
module acc_stack_monitor (
    input wire logic i_core_clk, // clock
    input wire logic i_rst, // reset
    input wire logic i_op_valid, // op offered
    input wire logic [2:0] i_op, // op code
    input wire logic [31:0] i_load_value, // load value
    input wire logic o_op_ready, // op can be taken
    input wire logic o_op_done, // op finished
    input wire logic [31:0] o_accumulator, // accumulator
    input wire logic [31:0] o_stack_level1, // stack top
    input wire logic o_operand_overflow_flag, // overflow
    input wire logic o_zero_result_flag, // zero
    input wire logic o_borrow16_flag, // borrow 16
    input wire logic o_borrow32_flag, // borrow 32
    input wire logic o_carry16_flag, // carry 16
    input wire logic o_carry32_flag, // carry 32
    input wire logic o_negative_flag, // negative
    input wire logic o_sign_error_flag, // sign error
    input wire logic o_bcd_format_error_flag // bcd error
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [31:0] pa;
    logic [31:0] ps;
    logic [16:0] s16;
    logic [32:0] s32;
    wire logic take = i_op_valid && o_op_ready;
    // operands as they stood at the taking edge
    always_ff @(posedge i_core_clk) begin
        pa <= o_accumulator;
        ps <= o_stack_level1;
    end
    assign s16 = {1'b0, pa[15:0]} + {1'b0, ps[15:0]};
    assign s32 = {1'b0, pa} + {1'b0, ps};
    chk_load_push: assert property (take && i_op == 3'h0 |=> o_op_done && o_stack_level1 == pa
        && o_accumulator == $past(i_load_value)) else $error("load push wrong");
    chk_add_sum: assert property (take && i_op == 3'h2 |=> o_accumulator == s32[31:0]
        && o_carry16_flag == s16[16] && o_carry32_flag == s32[32]) else $error("add wrong");
    chk_add_sign: assert property (take && i_op == 3'h2 |=>
        o_sign_error_flag == (pa[31] == ps[31] && s32[31] != pa[31])) else $error("sign error wrong");
    chk_sub_borrow: assert property (take && i_op == 3'h3 |=> o_accumulator == pa - ps
        && o_borrow32_flag == (pa < ps) && o_borrow16_flag == (pa[15:0] < ps[15:0])) else $error("sub wrong");
    chk_mul_prod: assert property (take && i_op == 3'h4 |=>
        o_accumulator == {16'h0, pa[15:0]} * {16'h0, ps[15:0]}) else $error("mul wrong");
    chk_zero_neg: assert property (take && i_op inside {3'h2, 3'h3, 3'h4} |=>
        o_zero_result_flag == (o_accumulator == 32'h0) && o_negative_flag == o_accumulator[31])
        else $error("zero or negative wrong");
    chk_div_refuse: assert property (take && i_op == 3'h5 && o_stack_level1 == 32'h0 |=>
        o_operand_overflow_flag && o_op_done && o_accumulator == pa) else $error("zero divisor taken");
    chk_div_time: assert property (take && i_op == 3'h5 && o_stack_level1 != 32'h0
        && o_stack_level1[31:16] == 16'h0 |=> !o_op_ready [*8] ##[25:27] o_op_done) else $error("div time");
    chk_bcd_digit: assert property (take && i_op == 3'h1 && o_stack_level1[3:0] > 4'h9 |=>
        o_bcd_format_error_flag && !o_operand_overflow_flag && o_accumulator == pa) else $error("bcd check");
    chk_flag_hold: assert property (take && i_op == 3'h4 |=> $stable(o_carry16_flag)
        && $stable(o_borrow16_flag) && $stable(o_sign_error_flag)) else $error("flag not held");
    cov_add: cover property (take && i_op == 3'h2 ##1 o_carry32_flag);
    cov_div: cover property (take && i_op == 3'h5 ##1 !o_operand_overflow_flag);
    cov_bcd: cover property ($rose(o_bcd_format_error_flag));
    cov_bcd_div: cover property (take && i_op == 3'h1 ##1 !o_bcd_format_error_flag && !o_operand_overflow_flag);
endmodule : acc_stack_monitor

bind accumulator_stack_arith acc_stack_monitor acc_stack_monitor_i (.i_core_clk, .i_rst, .i_op_valid, .i_op,
    .i_load_value, .o_op_ready, .o_op_done, .o_accumulator, .o_stack_level1, .o_operand_overflow_flag,
    .o_zero_result_flag, .o_borrow16_flag, .o_borrow32_flag, .o_carry16_flag, .o_carry32_flag,
    .o_negative_flag, .o_sign_error_flag, .o_bcd_format_error_flag);

// [bench/accumulator_stack_arith_tb.sv]
/* self-checking bench: a reference stack model is run beside the unit.
   assumes the sequencer model in seq_model.sv and the bound port checker. */
`timescale 1ns/10ps
module accumulator_stack_arith_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic op_valid;
    logic [2:0] op_code;
    logic [31:0] load_value;
    wire logic ready;
    wire logic done;
    wire logic [31:0] acc_seen;
    wire logic [31:0] top_seen;
    wire logic [8:0] fl_seen;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] acc;
    logic [7:0][31:0] stk;
    logic [8:0] fl;
    always #10 i_core_clk = ~i_core_clk;
    seq_model seq_model_i (.i_core_clk(i_core_clk), .i_op_ready(ready), .i_op_done(done),
        .o_op_valid(op_valid), .o_op(op_code), .o_value(load_value));
    accumulator_stack_arith accumulator_stack_arith_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_op_valid(op_valid), .i_op(op_code), .i_load_value(load_value), .o_op_ready(ready),
        .o_op_done(done), .o_accumulator(acc_seen), .o_stack_level1(top_seen),
        .o_operand_overflow_flag(fl_seen[8]), .o_zero_result_flag(fl_seen[7]), .o_borrow16_flag(fl_seen[6]),
        .o_borrow32_flag(fl_seen[5]), .o_carry16_flag(fl_seen[4]), .o_carry32_flag(fl_seen[3]),
        .o_negative_flag(fl_seen[2]), .o_sign_error_flag(fl_seen[1]), .o_bcd_format_error_flag(fl_seen[0]));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic bit is_bcd(input logic [31:0] x, input int n);
        for (int i = 0; i < n; i++) if (x[i*4+:4] > 4'h9) return 1'b0;
        return 1'b1;
    endfunction : is_bcd
    function automatic logic [31:0] to_bin(input logic [31:0] x);
        logic [31:0] r = 32'h0;
        for (int i = 7; i >= 0; i--) r = r * 10 + x[i*4+:4];
        return r;
    endfunction : to_bin
    function automatic logic [31:0] to_bcd(input logic [31:0] x);
        logic [31:0] r = 32'h0;
        for (int i = 0; i < 8; i++) begin
            r[i*4+:4] = 4'(x % 10);
            x = x / 10;
        end
        return r;
    endfunction : to_bcd
    task automatic do_op(input logic [2:0] op, input logic [31:0] v);
        bit ok;
        logic [32:0] s;
        logic [16:0] t;
        logic [31:0] q;
        logic [31:0] d;
        seq_model_i.issue(op, v, ok);
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
            wrap_up();
        end
        d = stk[0];
        // flag order: ovf zero b16 b32 c16 c32 neg sign bcd
        case (op)
            3'h0: begin
                stk = {stk[6:0], acc};
                acc = v;
            end
            3'h2: begin
                t = {1'b0, acc[15:0]} + {1'b0, d[15:0]};
                s = {1'b0, acc} + {1'b0, d};
                fl[4] = t[16];
                fl[3] = s[32];
                fl[1] = acc[31] == d[31] && s[31] != acc[31];
                acc = s[31:0];
            end
            3'h3: begin
                s = {1'b0, acc} - {1'b0, d};
                fl[6] = acc[15:0] < d[15:0];
                fl[5] = acc < d;
                fl[1] = acc[31] != d[31] && s[31] != acc[31];
                acc = s[31:0];
            end
            3'h4: acc = {16'h0, acc[15:0]} * {16'h0, d[15:0]};
            3'h5: begin
                fl[8] = d == 32'h0 || d[31:16] != 16'h0;
                if (!fl[8]) begin
                    q = acc / d;
                    stk[0] = acc % d;
                    acc = q;
                end
            end
            default: begin
                fl[0] = !is_bcd(acc, 8) || !is_bcd(d, 4);
                fl[8] = !fl[0] && (d == 32'h0 || d[31:16] != 16'h0);
                if (!fl[0] && !fl[8]) begin
                    q = to_bcd(to_bin(acc) / to_bin(d));
                    stk[0] = to_bcd(to_bin(acc) % to_bin(d));
                    acc = q;
                end
            end
        endcase
        if (op inside {3'h2, 3'h3, 3'h4}) stk = {32'h0, stk[7:1]};
        if (op != 3'h0) fl[7:7] = acc == 32'h0;
        if (op != 3'h0) fl[2] = acc[31];
        check(acc_seen, acc);
        check(top_seen, stk[0]);
        check({23'h0, fl_seen}, {23'h0, fl});
    endtask : do_op
    task automatic run(input logic [31:0] top, input logic [31:0] a, input logic [2:0] op);
        do_op(3'h0, top);
        do_op(3'h0, a);
        do_op(op, 32'h0);
    endtask : run
    initial begin
        acc = 32'h0;
        stk = '0;
        fl = 9'h0;
        repeat (6) @(negedge i_core_clk);
        i_rst = 1'b0;
        run(32'h0000_ffff, 32'h0000_0001, 3'h2);
        run(32'h7fff_ffff, 32'h0000_0001, 3'h2);
        run(32'hffff_ffff, 32'h0000_0001, 3'h2);
        do_op(3'h2, 32'h0);
        $display("test add done");
        run(32'h0000_0005, 32'h0000_0003, 3'h3);
        run(32'h8000_0000, 32'h0000_0001, 3'h3);
        $display("test subtract done");
        run(32'h1234_0003, 32'hffff_0005, 3'h4);
        run(32'h0000_ffff, 32'h0000_ffff, 3'h4);
        $display("test multiply done");
        run(32'h0000_0007, 32'hffff_fffe, 3'h5);
        run(32'h0000_0000, 32'h0000_0005, 3'h5);
        run(32'h0001_0000, 32'h0000_0005, 3'h5);
        run(32'h0000_ffff, 32'h0000_ffff, 3'h5);
        $display("test binary divide done");
        run(32'h0000_0007, 32'h0000_0100, 3'h1);
        run(32'h0000_000a, 32'h0000_0100, 3'h1);
        run(32'h0000_0007, 32'h0000_001f, 3'h1);
        run(32'h0000_0000, 32'h9999_9999, 3'h1);
        run(32'h0000_9999, 32'h9999_9999, 3'h1);
        $display("test bcd divide done");
        @(negedge i_core_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        acc = 32'h0;
        stk = '0;
        fl = 9'h0;
        do_op(3'h0, 32'h0000_0042);
        $display("test reset done");
        wrap_up();
    end
endmodule : accumulator_stack_arith_tb

// [bench/seq_model.sv]
/* instruction sequencer model: offers one operation and waits for its finish.
   assumes the unit samples valid on the rising edge; drives at the falling edge. */
`timescale 1ns/10ps
module seq_model (
    input wire logic i_core_clk, // clock
    input wire logic i_op_ready, // unit can take
    input wire logic i_op_done, // finish pulse
    output logic o_op_valid, // op offered
    output logic [2:0] o_op, // op code
    output logic [31:0] o_value // load value
);
    initial begin
        o_op_valid = 1'b0;
        o_op = 3'h0;
        o_value = 32'h0;
    end
    task automatic issue(input logic [2:0] op, input logic [31:0] val, output bit ok);
        int n;
        n = 0;
        @(negedge i_core_clk);
        o_op_valid <= 1'b1;
        o_op <= op;
        o_value <= val;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (i_op_ready !== 1'b1 && n < 60);
        @(negedge i_core_clk);
        o_op_valid <= 1'b0;
        // released lines show garbage, not the last value
        o_op <= ~op;
        o_value <= ~val;
        while (i_op_done !== 1'b1 && n < 60) begin
            @(negedge i_core_clk);
            n++;
        end
        ok = (i_op_done === 1'b1);
    endtask : issue
endmodule : seq_model

// [include/acc_stack_pkg.sv]
/*
 * types shared by the accumulator stack arithmetic unit: operation codes and sequencer states.
 * assumes nothing of its surroundings; it holds types only.
 */
package acc_stack_pkg;

    typedef enum logic [2:0] {
        OP_LOAD = 3'b000,
        OP_BCD_DIV = 3'b001,
        OP_BIN_ADD = 3'b010,
        OP_BIN_SUB = 3'b011,
        OP_BIN_MUL = 3'b100,
        OP_BIN_DIV = 3'b101
    } op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DIVIDE = 1'b1
    } seq_state_t;

endpackage : acc_stack_pkg

// [include/acc_stack_regs.svh]
/*
 * reset values, stack depth and divide operand widths and digit counts of the accumulator stack arithmetic unit.
 * assumes it is included by bare name by the design modules.
 */
`ifndef ACC_STACK_REGS_SVH
`define ACC_STACK_REGS_SVH

`define ACC_RESET_VALUE 32'h0000_0000
`define STACK_RESET_VALUE 32'h0000_0000
`define STACK_DEPTH_DEFAULT 8
`define DIVIDEND_WIDTH 32
`define DIVISOR_WIDTH 16
`define BCD_DIVIDEND_DIGITS 8
`define BCD_DIVISOR_DIGITS 4

`endif

// [rtl/accumulator_stack_arith.sv]
/*
 * accumulator with its stack and the stack arithmetic: BCD divide and binary
 * add, subtract, multiply and divide, with their status flags.
 * assumes the instruction sequencer runs on the same clock, offers one
 * operation at a time and holds it until o_op_ready accepts it.
 */
`timescale 1ns/10ps
`include "acc_stack_regs.svh"

module accumulator_stack_arith #(
    parameter int STACK_DEPTH = `STACK_DEPTH_DEFAULT
) (
    input wire logic i_core_clk, // core clock, 50 MHz
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_op_valid, // operation offered
    input wire logic [2:0] i_op, // operation code
    input wire logic [31:0] i_load_value, // value for a load
    output logic o_op_ready, // operation can be taken
    output logic o_op_done, // one-cycle pulse, operation finished
    output logic [31:0] o_accumulator, // accumulator
    output logic [31:0] o_stack_level1, // first stack level
    output logic o_operand_overflow_flag, // divisor too large or zero
    output logic o_zero_result_flag, // accumulator is zero
    output logic o_borrow16_flag, // borrow of low 16 bits
    output logic o_borrow32_flag, // borrow of 32 bits
    output logic o_carry16_flag, // carry out of bit 15
    output logic o_carry32_flag, // carry out of bit 31
    output logic o_negative_flag, // accumulator negative
    output logic o_sign_error_flag, // signed overflow
    output logic o_bcd_format_error_flag // non-BCD operand seen
);

    initial begin
        if (STACK_DEPTH < 2) begin
            $error("accumulator_stack_arith: stack depth must be at least 2");
        end
    end

    localparam int DW = `DIVIDEND_WIDTH;
    localparam int SW = `DIVISOR_WIDTH;

    function automatic logic bcd_valid(input logic [31:0] v, input int digits);
        logic ok;
        ok = 1'b1;
        for (int d = 0; d < 8; d++) begin
            if (d < digits && v[4*d +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcd_valid

    function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int d = 7; d >= 0; d--) begin
            r = 32'((r * 32'h0000_000a) + {28'h0000000, v[4*d +: 4]});
        end
        return r;
    endfunction : bcd_to_bin

    function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
        logic [31:0] b;
        b = 32'h0000_0000;
        for (int i = 31; i >= 0; i--) begin
            for (int d = 0; d < 8; d++) begin
                if (b[4*d +: 4] >= 4'h5) begin
                    b[4*d +: 4] = b[4*d +: 4] + 4'h3;
                end
            end
            b = {b[30:0], v[i]};
        end
        return b;
    endfunction : bin_to_bcd

    acc_stack_pkg::seq_state_t state;
    logic [31:0] stack [STACK_DEPTH];
    logic div_is_bcd;

    acc_stack_pkg::op_t op;
    logic take;
    logic [32:0] sum;
    logic [16:0] sum_low;
    logic [32:0] diff;
    logic [16:0] diff_low;
    logic [31:0] product;
    logic bcd_ok;
    logic [31:0] bcd_dividend;
    logic [31:0] bcd_divisor;
    logic bin_div_bad;
    logic bcd_div_bad;
    logic div_start;
    logic [31:0] div_dividend;
    logic [15:0] div_divisor;
    logic div_done;
    logic [31:0] div_quotient;
    logic [15:0] div_remainder;
    logic [31:0] next_accumulator;
    logic [31:0] div_result;
    logic [31:0] div_rest;

    assign op = acc_stack_pkg::op_t'(i_op);
    assign o_op_ready = (state == acc_stack_pkg::ST_IDLE);
    assign take = i_op_valid && o_op_ready;
    assign o_stack_level1 = stack[0];

    assign sum = {1'b0, o_accumulator} + {1'b0, stack[0]};
    assign sum_low = {1'b0, o_accumulator[15:0]} + {1'b0, stack[0][15:0]};
    assign diff = {1'b0, o_accumulator} - {1'b0, stack[0]};
    assign diff_low = {1'b0, o_accumulator[15:0]} - {1'b0, stack[0][15:0]};
    assign product = {16'h0000, o_accumulator[15:0]} * {16'h0000, stack[0][15:0]};

    // BCD divide checks and conversion
    assign bcd_ok = bcd_valid(o_accumulator, `BCD_DIVIDEND_DIGITS) && bcd_valid(stack[0], `BCD_DIVISOR_DIGITS);
    assign bcd_dividend = bcd_to_bin(o_accumulator);
    assign bcd_divisor = bcd_to_bin({16'h0000, stack[0][15:0]});
    assign bcd_div_bad = !bcd_ok || stack[0][31:16] != 16'h0000 || stack[0][15:0] == 16'h0000;
    assign bin_div_bad = stack[0][31:16] != 16'h0000 || stack[0][15:0] == 16'h0000;

    always_comb begin
        div_start = 1'b0;
        div_dividend = o_accumulator;
        div_divisor = stack[0][15:0];
        if (take && op == acc_stack_pkg::OP_BCD_DIV && !bcd_div_bad) begin
            div_start = 1'b1;
            div_dividend = bcd_dividend;
            div_divisor = bcd_divisor[15:0];
        end else if (take && op == acc_stack_pkg::OP_BIN_DIV && !bin_div_bad) begin
            div_start = 1'b1;
        end
    end

    stack_divider #(
        .DIVIDEND_W(DW),
        .DIVISOR_W(SW)
    ) u_divider (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(div_start),
        .i_dividend(div_dividend),
        .i_divisor(div_divisor),
        .o_busy(),
        .o_done(div_done),
        .o_quotient(div_quotient),
        .o_remainder(div_remainder)
    );

    // quotient and remainder back in the accumulator's number format
    assign div_result = div_is_bcd ? bin_to_bcd(div_quotient) : div_quotient;
    assign div_rest = div_is_bcd ? bin_to_bcd({16'h0000, div_remainder}) : {16'h0000, div_remainder};

    always_comb begin
        next_accumulator = o_accumulator;
        if (state == acc_stack_pkg::ST_DIVIDE) begin
            if (div_done) begin
                next_accumulator = div_result;
            end
        end else if (take) begin
            case (op)
                acc_stack_pkg::OP_LOAD: next_accumulator = i_load_value;
                acc_stack_pkg::OP_BIN_ADD: next_accumulator = sum[31:0];
                acc_stack_pkg::OP_BIN_SUB: next_accumulator = diff[31:0];
                acc_stack_pkg::OP_BIN_MUL: next_accumulator = product;
                default: next_accumulator = o_accumulator;
            endcase
        end
    end

    // sequencer
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= acc_stack_pkg::ST_IDLE;
            div_is_bcd <= 1'b0;
        end else if (state == acc_stack_pkg::ST_DIVIDE) begin
            if (div_done) begin
                state <= acc_stack_pkg::ST_IDLE;
            end
        end else if (div_start) begin
            state <= acc_stack_pkg::ST_DIVIDE;
            div_is_bcd <= (op == acc_stack_pkg::OP_BCD_DIV);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_op_done <= 1'b0;
        end else if (state == acc_stack_pkg::ST_DIVIDE) begin
            o_op_done <= div_done;
        end else begin
            case (op)
                acc_stack_pkg::OP_LOAD, acc_stack_pkg::OP_BIN_ADD, acc_stack_pkg::OP_BIN_SUB,
                acc_stack_pkg::OP_BIN_MUL: o_op_done <= take;
                acc_stack_pkg::OP_BCD_DIV: o_op_done <= take && bcd_div_bad;
                acc_stack_pkg::OP_BIN_DIV: o_op_done <= take && bin_div_bad;
                default: o_op_done <= 1'b0;
            endcase
        end
    end

    // accumulator
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_accumulator <= `ACC_RESET_VALUE;
        end else begin
            o_accumulator <= next_accumulator;
        end
    end

    // stack: push on load, pop after add, subtract and multiply
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= `STACK_RESET_VALUE;
            end
        end else if (state == acc_stack_pkg::ST_DIVIDE) begin
            if (div_done) begin
                stack[0] <= div_rest;
            end
        end else if (take) begin
            case (op)
                acc_stack_pkg::OP_LOAD: begin
                    stack[0] <= o_accumulator;
                    for (int i = 1; i < STACK_DEPTH; i++) begin
                        stack[i] <= stack[i-1];
                    end
                end
                acc_stack_pkg::OP_BIN_ADD, acc_stack_pkg::OP_BIN_SUB, acc_stack_pkg::OP_BIN_MUL: begin
                    for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                        stack[i] <= stack[i+1];
                    end
                    stack[STACK_DEPTH-1] <= `STACK_RESET_VALUE;
                end
                default: begin
                end
            endcase
        end
    end

    // zero and negative follow every arithmetic result; loads leave them
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_zero_result_flag <= 1'b0;
            o_negative_flag <= 1'b0;
        end else if ((state == acc_stack_pkg::ST_DIVIDE && div_done)
                     || (take && (op == acc_stack_pkg::OP_BIN_ADD || op == acc_stack_pkg::OP_BIN_SUB
                                  || op == acc_stack_pkg::OP_BIN_MUL || op == acc_stack_pkg::OP_BCD_DIV
                                  || op == acc_stack_pkg::OP_BIN_DIV))) begin
            o_zero_result_flag <= (next_accumulator == 32'h0000_0000);
            o_negative_flag <= next_accumulator[31];
        end
    end

    // overflow is settled when a divide is taken, BCD error only when a BCD divide is taken
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_operand_overflow_flag <= 1'b0;
            o_bcd_format_error_flag <= 1'b0;
        end else if (take && op == acc_stack_pkg::OP_BCD_DIV) begin
            o_operand_overflow_flag <= bcd_ok && bcd_div_bad;
            o_bcd_format_error_flag <= !bcd_ok;
        end else if (take && op == acc_stack_pkg::OP_BIN_DIV) begin
            o_operand_overflow_flag <= bin_div_bad;
        end
    end

    // carry flags belong to add, borrow flags to subtract
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_carry16_flag <= 1'b0;
            o_carry32_flag <= 1'b0;
            o_borrow16_flag <= 1'b0;
            o_borrow32_flag <= 1'b0;
        end else if (take && op == acc_stack_pkg::OP_BIN_ADD) begin
            o_carry16_flag <= sum_low[16];
            o_carry32_flag <= sum[32];
        end else if (take && op == acc_stack_pkg::OP_BIN_SUB) begin
            o_borrow16_flag <= diff_low[16];
            o_borrow32_flag <= diff[32];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_sign_error_flag <= 1'b0;
        end else if (take && op == acc_stack_pkg::OP_BIN_ADD) begin
            o_sign_error_flag <= (o_accumulator[31] == stack[0][31]) && (sum[31] != o_accumulator[31]);
        end else if (take && op == acc_stack_pkg::OP_BIN_SUB) begin
            o_sign_error_flag <= (o_accumulator[31] != stack[0][31]) && (diff[31] != o_accumulator[31]);
        end
    end

endmodule : accumulator_stack_arith

// [rtl/stack_divider.sv]
/*
 * sequential restoring divider, one quotient bit per clock.
 * assumes the caller holds i_start for one cycle only while o_busy is low and
 * never passes a zero divisor; a zero divisor gives a quotient bit of 1 only while the top remainder bit is clear.
 */
`timescale 1ns/10ps
`include "acc_stack_regs.svh"

module stack_divider #(
    parameter int DIVIDEND_W = `DIVIDEND_WIDTH,
    parameter int DIVISOR_W = `DIVISOR_WIDTH
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_start, // one-cycle start pulse
    input wire logic [DIVIDEND_W-1:0] i_dividend, // dividend
    input wire logic [DIVISOR_W-1:0] i_divisor, // divisor, nonzero
    output logic o_busy, // division in progress
    output logic o_done, // one-cycle pulse, results valid
    output logic [DIVIDEND_W-1:0] o_quotient, // quotient
    output logic [DIVISOR_W-1:0] o_remainder // remainder
);

    localparam int CNT_W = $clog2(DIVIDEND_W);
    localparam logic [CNT_W-1:0] LAST_STEP = CNT_W'(DIVIDEND_W - 1);

    initial begin
        if (DIVIDEND_W < 2 || DIVISOR_W < 1 || DIVISOR_W > DIVIDEND_W) begin
            $error("stack_divider: unsupported widths");
        end
    end

    logic [CNT_W-1:0] step;
    logic [DIVISOR_W-1:0] divisor;
    logic [DIVISOR_W:0] shifted;
    logic [DIVISOR_W:0] trial;

    assign shifted = {o_remainder, o_quotient[DIVIDEND_W-1]};
    assign trial = shifted - {1'b0, divisor};

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            step <= '0;
            divisor <= '0;
            o_quotient <= '0;
            o_remainder <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                o_busy <= 1'b1;
                step <= '0;
                divisor <= i_divisor;
                o_quotient <= i_dividend;
                o_remainder <= '0;
            end else if (o_busy) begin
                // trial subtraction: keep the difference when no borrow
                if (!trial[DIVISOR_W]) begin
                    o_remainder <= trial[DIVISOR_W-1:0];
                    o_quotient <= {o_quotient[DIVIDEND_W-2:0], 1'b1};
                end else begin
                    o_remainder <= shifted[DIVISOR_W-1:0];
                    o_quotient <= {o_quotient[DIVIDEND_W-2:0], 1'b0};
                end
                step <= step + CNT_W'(1);
                if (step == LAST_STEP) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule : stack_divider
